// ---- verilog/dbf_pkg.sv ----
// Package: register map, field positions and reset values of the DAC control
package dbf_pkg;

  // Register indices; the byte address on APB is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_IRQ_EN_CLR = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN_SET = 6'h05;
  localparam logic [5:0] IDX_INTFLAG = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_DATA = 6'h08;
  localparam logic [5:0] IDX_PEND_BUF = 6'h0c;

  // Field positions
  localparam int BIT_ENABLE = 1;
  localparam int BIT_UNDERRUN = 0;
  localparam int BIT_EMPTY = 1;
  localparam int BIT_SYNC_READY = 2;
  localparam int BIT_SYNC_PENDING = 7;
  localparam int NUM_FLAGS = 3;

  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [2:0] RST_INTEN = 3'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic RST_BUF_FULL = 1'b0;

  // Defaults for the top module parameters
  localparam int DAC_BITS_DEF = 10;
  localparam int SYNC_CYCLES_DEF = 3;

endpackage : dbf_pkg

// ---- verilog/dbf_evt_sync.sv ----
// Start-conversion event input: two-stage synchroniser and edge detector
`timescale 1ns/1ps
module dbf_evt_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous event level and one-cycle event pulse
  input wire logic evt_async,
  output logic evt_pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } dbf_evt_state_type;

  dbf_evt_state_type s_q;
  dbf_evt_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Only the second stage feeds the edge detector, never the first
  always_comb
  begin
    s_d = s_q;
    s_d.meta = evt_async;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
    s_d.pulse = s_q.sync & ~s_q.last;
  end

  // Synchronous reset to constants
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign evt_pulse = s_q.pulse;

endmodule : dbf_evt_sync

// ---- verilog/dbf_top.sv ----
// DAC control: pending sample buffer, active data, flags and APB registers
//
// Behaviour
// - One conversion channel; each converted code is DAC_BITS bits (10 by default) from active data.
// - Buffer-empty flag (bit 1) sets when buffered sample moves to active data.
// - Buffer-empty clears on write-one, or on a new write to the buffer.
// - Underrun flag (bit 0) sets on a start event with an empty buffer.
// - Interrupt asserts only while a flag is set and its enable is one.
// - Writing one clears underrun or buffer-empty; writing zero changes nothing.
// - Writing one at enable-clear bit 2 disables sync-ready interrupt; reads enable.
// - Sync-pending bit 7 of status sets when a crossing starts, clears when done.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module dbf_top
  import dbf_pkg::*;
#(
  parameter int DAC_BITS = dbf_pkg::DAC_BITS_DEF,
  parameter int SYNC_CYCLES = dbf_pkg::SYNC_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Start-conversion event, asynchronous level
  input wire logic START_EVT,
  // Converter code and interrupt
  output logic [DAC_BITS-1:0] DAC_CODE,
  output logic IRQ
);

  localparam int CW = $clog2(SYNC_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    if (DAC_BITS < 1 || DAC_BITS > 32)
    begin : g_bad_bits
      $error("DAC_BITS must lie between 1 and 32");
    end
    if (SYNC_CYCLES < 1)
    begin : g_bad_sync
      $error("SYNC_CYCLES must be at least 1");
    end
    if (BIT_UNDERRUN >= NUM_FLAGS || BIT_EMPTY >= NUM_FLAGS ||
        BIT_SYNC_READY >= NUM_FLAGS)
    begin : g_bad_flags
      $error("Flag positions must lie inside the flag field");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic enable;
    logic [2:0] inten;
    logic [2:0] flags;
    logic [DAC_BITS-1:0] pend;
    logic pend_full;
    logic [DAC_BITS-1:0] data;
    logic busy;
    logic [CW-1:0] cnt;
    logic irq;
  } dbf_state_type;

  dbf_state_type s_q;
  dbf_state_type s_d;

  logic evt;

  // Event synchroniser; the pin is asynchronous to REF_CLK
  // The price is a few cycles of latency after the pin rises
  dbf_evt_sync u_evt
  (
    .clk (REF_CLK),
    .rst (RST),
    .evt_async (START_EVT),
    .evt_pulse (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic access;
  logic wr_fire;

  assign idx = PADDR[7:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  // Answer one cycle into the access phase; the transfer ends on pready
  // Registered answer, so every transfer has one fixed wait state
  assign access = PSEL & PENABLE & ~s_q.pready;
  assign wr_fire = PSEL & PENABLE & s_q.pready & PWRITE & mapped;

  // Address map check; unmapped or unaligned words answer with an error
  // and write nothing
  always_comb
  begin
    mapped = 1'b0;
    if (aligned)
    begin
      case (idx)
        IDX_CTRL, IDX_IRQ_EN_CLR, IDX_IRQ_EN_SET, IDX_INTFLAG,
        IDX_STATUS, IDX_DATA, IDX_PEND_BUF:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; reserved bits read zero
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0;
    case (idx)
      IDX_CTRL:
        rd_word[BIT_ENABLE] = s_q.enable;
      IDX_IRQ_EN_CLR, IDX_IRQ_EN_SET:
        rd_word[2:0] = s_q.inten;
      IDX_INTFLAG:
        rd_word[2:0] = s_q.flags;
      IDX_STATUS:
        rd_word[BIT_SYNC_PENDING] = s_q.busy;
      IDX_DATA:
        rd_word[DAC_BITS-1:0] = s_q.data;
      IDX_PEND_BUF:
        rd_word[DAC_BITS-1:0] = s_q.pend;
      default:
        rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes per register
  logic wr_ctrl;
  logic wr_iclr;
  logic wr_iset;
  logic wr_flag;
  logic wr_data;
  logic wr_buf;

  assign wr_ctrl = wr_fire & (idx == IDX_CTRL);
  assign wr_iclr = wr_fire & (idx == IDX_IRQ_EN_CLR);
  assign wr_iset = wr_fire & (idx == IDX_IRQ_EN_SET);
  assign wr_flag = wr_fire & (idx == IDX_INTFLAG);
  assign wr_data = wr_fire & (idx == IDX_DATA);
  assign wr_buf = wr_fire & (idx == IDX_PEND_BUF);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion events and flag sources
  logic conv_evt;
  logic take_sample;
  logic underrun_set;
  logic empty_set;
  logic sync_ready_set;
  logic sync_start;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // Events are ignored while the converter is disabled
  assign conv_evt = evt & s_q.enable;
  assign take_sample = conv_evt & s_q.pend_full;
  assign underrun_set = conv_evt & ~s_q.pend_full;
  // Converter is ready for the next sample as soon as it moves on
  assign empty_set = take_sample;
  // Register writes that must reach the converter domain
  assign sync_start = wr_ctrl | wr_data | wr_buf;
  assign sync_ready_set = s_q.busy & (s_q.cnt == CW'(1)) & ~sync_start;

  // Sources that set each sticky flag
  always_comb
  begin
    flag_set = 3'h0;
    flag_set[BIT_UNDERRUN] = underrun_set;
    flag_set[BIT_EMPTY] = empty_set;
    flag_set[BIT_SYNC_READY] = sync_ready_set;
  end

  // Write-one clears; a buffer write also clears buffer-empty
  // Data bits above the flag field are ignored
  always_comb
  begin
    flag_clr = 3'h0;
    if (wr_flag)
    begin
      flag_clr = PWDATA[2:0];
    end
    if (wr_buf)
    begin
      flag_clr[BIT_EMPTY] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables: clear and set views of one register; a clear and a
  // set never meet in one cycle, as they sit at different addresses
  logic [2:0] inten_nxt;

  always_comb
  begin
    inten_nxt = s_q.inten;
    if (wr_iclr)
    begin
      inten_nxt = s_q.inten & ~PWDATA[2:0];
    end
    else if (wr_iset)
    begin
      inten_nxt = s_q.inten | PWDATA[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-flag update and interrupt source. A set that meets a write-one
  // clear in the same cycle wins, so an event racing software is not lost.
  // The source uses the next flags and next enables, so IRQ moves at the edge of its cause.
  logic [2:0] flag_nxt;
  logic [2:0] irq_src;

  generate
    for (genvar i = 0; i < NUM_FLAGS; i++)
    begin : g_flag
      assign flag_nxt[i] = (s_q.flags[i] & ~flag_clr[i]) | flag_set[i];
      assign irq_src[i] = flag_nxt[i] & inten_nxt[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;

    // APB answer: ready one cycle into the access phase
    s_d.pready = access;
    s_d.pslverr = access & ~mapped;
    if (access)
    begin
      s_d.prdata = (mapped && !PWRITE) ? rd_word : 32'h0;
    end

    // Control register
    if (wr_ctrl)
    begin
      s_d.enable = PWDATA[BIT_ENABLE];
    end

    // Interrupt enables and sticky flags come from their own logic
    s_d.inten = inten_nxt;
    s_d.flags = flag_nxt;

    // Active data: direct write or move from the pending buffer
    // A move beats a direct write so the sample stream keeps its order
    if (take_sample)
    begin
      s_d.data = s_q.pend;
    end
    else if (wr_data)
    begin
      s_d.data = PWDATA[DAC_BITS-1:0];
    end

    // Pending buffer; a write in the event cycle refills it after the old
    // sample has moved on, so neither sample is lost
    if (take_sample)
    begin
      s_d.pend_full = 1'b0;
    end
    if (wr_buf)
    begin
      s_d.pend = PWDATA[DAC_BITS-1:0];
      s_d.pend_full = 1'b1;
    end

    // Domain crossing emulation: a fixed transfer time per write;
    // a new write restarts the count so busy covers the latest one
    if (sync_start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = CW'(SYNC_CYCLES);
    end
    else if (s_q.busy)
    begin
      s_d.cnt = s_q.cnt - CW'(1);
      if (s_q.cnt == CW'(1))
      begin
        s_d.busy = 1'b0;
      end
    end

    // Level interrupt from the next flags, so IRQ follows flags exactly
    s_d.irq = |irq_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  // Every field restarts at zero; the bus reads zeros until written
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= 32'h0;
      s_q.enable <= RST_ENABLE;
      s_q.inten <= RST_INTEN;
      s_q.flags <= RST_FLAGS;
      s_q.pend <= '0;
      s_q.pend_full <= RST_BUF_FULL;
      s_q.data <= '0;
      s_q.busy <= 1'b0;
      s_q.cnt <= '0;
      s_q.irq <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign DAC_CODE = s_q.data;
  assign IRQ = s_q.irq;

endmodule : dbf_top

// ---- test/dbf_evt_src.sv ----
// Start-conversion event source on the far side of the block
`timescale 1ns/1ps
module dbf_evt_src
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request and event line
  input wire logic fire,
  output logic evt
);
  logic [2:0] cnt_q;
  // Four cycles high, then low; keeps the spacing the synchroniser needs
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 3'h0;
    else if (fire && cnt_q == 3'h0)
      cnt_q <= 3'h7;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
  assign evt = cnt_q[2];
endmodule : dbf_evt_src

// ---- test/dbf_props.sv ----
// Port-level assertions for the DAC buffer and flag control
`timescale 1ns/1ps
module dbf_props
#(
  parameter int DAC_BITS = 10
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Event, code and interrupt
  input wire logic START_EVT,
  input wire logic [DAC_BITS-1:0] DAC_CODE,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // Bus answer timing and content
  a_ready_one_wait: assert property (PSEL && !PENABLE |-> ##2 PREADY)
    else $error("answer not two edges after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready held too long");
  a_err_no_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer carries data");
  a_write_reads_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
    else $error("write answer carries data");
  a_status_only_bit7: assert property (
    PREADY && !PWRITE && PADDR == 8'h1c |-> PRDATA[31:8] == 24'h0
    && PRDATA[6:0] == 7'h0)
    else $error("status has bits besides bit 7");
  a_reset_quiet: assert property ($fell(RST) |-> !PREADY && !IRQ
    && DAC_CODE == '0)
    else $error("outputs not idle after reset");
  // Code moves only after a bus write or an event a few edges back
  a_code_needs_cause: assert property (
    $changed(DAC_CODE) |-> $past(PSEL && PWRITE) || $past(START_EVT, 2)
    || $past(START_EVT, 3) || $past(START_EVT, 4))
    else $error("code changed without cause");
  a_irq_fall_write: assert property (
    $fell(IRQ) |-> $past(PSEL && PWRITE))
    else $error("irq dropped without a write");
endmodule : dbf_props

bind dbf_top dbf_props #(.DAC_BITS(DAC_BITS)) u_dbf_props (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .START_EVT(START_EVT),
  .DAC_CODE(DAC_CODE), .IRQ(IRQ));

// ---- test/dac_buffer_and_flags_test.sv ----
// Self-checking bench for the DAC buffer and flag control
`timescale 1ns/1ps
module dac_buffer_and_flags_test;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic fire, evt, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] dac_code;
  int err_count = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////
  // Long sync count so the busy bit is still seen by the next read
  dbf_top #(.SYNC_CYCLES(8)) u_dbf_top (.REF_CLK(ref_clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .START_EVT(evt), .DAC_CODE(dac_code), .IRQ(irq));
  dbf_evt_src u_dbf_evt_src (.clk(ref_clk), .rst(rst), .fire(fire),
    .evt(evt));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // One transfer; only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, rd & m);
  endtask : rchk
  // Irq is looked at mid-cycle, after the edge's updates landed
  task automatic irqchk(input logic e);
    @(negedge ref_clk);
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask : irqchk
  task automatic pulse;
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask : pulse
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    conclude;
  end
  // Main sequence
  initial
  begin
    {rst, psel, penable, pwrite, fire} = 5'h10;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(8'h1c, 32'hffffffff, 32'h0);
    rchk(8'h18, 32'hffffffff, 32'h0);
    rchk(8'h14, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, 8'h00, 32'h2);
    rchk(8'h1c, 32'hffffffff, 32'h80);
    repeat (12) @(posedge ref_clk);
    rchk(8'h1c, 32'hffffffff, 32'h0);
    apb(1'b1, 8'h14, 32'h7);
    irqchk(1'b1);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h10, 32'h0);
    rchk(8'h10, 32'hffffffff, 32'h3);
    irqchk(1'b0);
    pulse;
    rchk(8'h18, 32'h3, 32'h1);
    irqchk(1'b1);
    apb(1'b1, 8'h18, 32'h0);
    rchk(8'h18, 32'h3, 32'h1);
    apb(1'b1, 8'h18, 32'h7);
    irqchk(1'b0);
    apb(1'b1, 8'h30, 32'h3a5);
    pulse;
    cmp("code", 32'h3a5, {22'h0, dac_code});
    rchk(8'h18, 32'h3, 32'h2);
    apb(1'b1, 8'h30, 32'h3ff);
    rchk(8'h18, 32'h3, 32'h0);
    pulse;
    cmp("code", 32'h3ff, {22'h0, dac_code});
    apb(1'b1, 8'h18, 32'h2);
    rchk(8'h18, 32'h3, 32'h0);
    // Direct write of the active data; look once the edge has settled
    apb(1'b1, 8'h20, 32'h155);
    @(negedge ref_clk);
    cmp("code", 32'h155, {22'h0, dac_code});
    rchk(8'h20, 32'h3ff, 32'h155);
    conclude;
  end
endmodule : dac_buffer_and_flags_test
